/* baud_counter_timer.sv */
// Rate generator, clock selectors, counter/timer and interrupt gathering
//
// What this block does
// RQ1: Generator table of standard rates from reference.
// RQ2: Extended mode bit adds three high rates to rate set B.
// RQ3: Every generator clock is sixteen times bit rate.
// RQ4: System supplies proper reference frequency.
// RQ5: Independent receive and transmit clock selection.
// RQ6: Sixteen-bit divider: counter, timer, timeout modes.
// RQ7: Auxiliary bits six to four pick source, mode.
// RQ8: Counter output feeds baud select and the lowest pin.
// RQ9: Ready bit set on output falling edge.
// RQ10: Reserved reads start and stop the counter.
// RQ11: Start copies preset into the counting register.
// RQ12: Stop clears the counter ready bit.
// RQ13: Timer square wave, half period equals preset.
// RQ14: Timer divides reference or pin for 16x.
// RQ15: One active-low interrupt from eight conditions.
// RQ16: Only masked-in conditions assert the interrupt.
// RQ17: Status shows active conditions regardless of mask.
// RQ18: Upper output pins as open-drain interrupts.
// RQ19: Counter mode: fall at zero, then wraps silently.
// RQ20: Commands switch timeout mode on and off.
// RQ21: Received character stops, reloads, restarts counter.
// RQ22: Upper preset is high byte, lower is low.
`timescale 1ns/1ps
`default_nettype none
`include "baud_ct_defines.svh"
module baud_counter_timer #(
	parameter int DIV_W = 16,
	parameter int OP_N = 5
) (
	input wire logic sys_clk, // System clock, 10 MHz
	input wire logic sys_rst, // Synchronous reset, high
	input wire logic ref_clock_in, // Reference clock pin
	input wire logic ct_clk_pin, // External counter/timer clock pin
	input wire logic rx_clk_pin, // External receive clock pin
	input wire logic tx_clk_pin, // External transmit clock pin
	input wire logic [7:0] extended_mode_reg, // Bit 0 unlocks high rates
	input wire logic [7:0] aux_control_reg, // Rate set, mode, source
	input wire logic [3:0] rx_clk_sel, // Receive clock select code
	input wire logic [3:0] tx_clk_sel, // Transmit clock select code
	input wire logic [7:0] preset_low_reg, // Preset bits 7..0
	input wire logic [7:0] preset_high_reg, // Preset bits 15..8
	input wire logic ct_start_rd, // Pulse: read of the start address
	input wire logic ct_stop_rd, // Pulse: read of the stop address
	input wire logic cmd_wr, // Pulse: command register write
	input wire logic [7:0] command_reg, // Command register data
	input wire logic rx_char_loaded, // Pulse: character moved to receive_queue
	input wire logic [7:0] irq_events, // Other conditions, bit 3 unused
	input wire logic [7:0] irq_mask_reg, // Interrupt mask
	input wire logic [OP_N-1:0] op_irq_en, // Pin acts as interrupt output
	input wire logic op_ct_out_en, // Lowest pin carries counter output
	input wire logic [OP_N-1:0] gp_out_data, // Plain output pin levels
	output logic rx_clk_en, // Pulse: receive clock tick
	output logic tx_clk_en, // Pulse: transmit clock tick
	output logic rx_clk_1x, // Receive tick is a 1x clock
	output logic tx_clk_1x, // Transmit tick is a 1x clock
	output logic sample_clk_en, // Pulse: 38.4 kHz sampling tap
	output logic ct_out, // Counter/timer output level
	output logic [15:0] ct_count, // Present counting register
	output logic timeout_on, // Receive timeout mode active
	output logic [7:0] irq_status_reg, // Active conditions
	output logic irq_out_n, // Interrupt, active low
	output logic [OP_N-1:0] gp_out_pins_hi_o, // Pin output level
	output logic [OP_N-1:0] gp_out_pins_hi_oe // Pin output enable
);

	////////////////////////////////////////////////////////////////////
	// Functions

	// Generator divisor in reference edges for one 16x tick
	function automatic logic [DIV_W-1:0] rate_div(
		input logic [3:0] code,
		input logic set_b,
		input logic ext_en
	);
		logic [15:0] d;
		d = 16'h0060;
		if (!set_b) begin
			unique case (code)
				4'h0: d = 16'h1200;
				4'h1: d = 16'h082F;
				4'h2: d = 16'h06B1;
				4'h3: d = 16'h0480;
				4'h4: d = 16'h0300;
				4'h5: d = 16'h0180;
				4'h6: d = 16'h00C0;
				4'h7: d = 16'h00DB;
				4'h8: d = 16'h0060;
				4'h9: d = 16'h0030;
				4'hA: d = 16'h0020;
				4'hB: d = 16'h0018;
				4'hC: d = 16'h0006;
				default: d = 16'h0060;
			endcase
		end else begin
			unique case (code)
				4'h0: d = ext_en ? 16'h0004 : 16'h0C00; // [RQ2]
				4'h1: d = ext_en ? 16'h0002 : 16'h082F; // [RQ2]
				4'h2: d = ext_en ? 16'h0001 : 16'h06B1; // [RQ2]
				4'h3: d = 16'h0600;
				4'h4: d = 16'h0300;
				4'h5: d = 16'h0180;
				4'h6: d = 16'h00C0;
				4'h7: d = 16'h0073;
				4'h8: d = 16'h0060;
				4'h9: d = 16'h0030;
				4'hA: d = 16'h0080;
				4'hB: d = 16'h0018;
				4'hC: d = 16'h000C;
				default: d = 16'h0060;
			endcase
		end
		return d[DIV_W-1:0];
	endfunction : rate_div

	// One selector: generator tap, counter output or external pin
	function automatic logic sel_tick(
		input logic [3:0] code,
		input logic gen,
		input logic ct,
		input logic pin
	);
		logic t;
		t = gen;
		case (code)
			`CSR_CT: t = ct;
			`CSR_EXT16: t = pin;
			`CSR_EXT1: t = pin;
			default: t = gen;
		endcase
		return t;
	endfunction : sel_tick

	// Which status bit a discrete interrupt pin reports
	function automatic int op_src(input int idx);
		int s;
		s = `ISR_TX_POS;
		case (idx)
			0: s = `ISR_CT_POS;
			1: s = `ISR_RX_POS;
			2: s = `ISR_TX_POS;
			3: s = `ISR_RX_POS;
			default: s = `ISR_TX_POS;
		endcase
		return s;
	endfunction : op_src

	////////////////////////////////////////////////////////////////////
	// Pin synchronisers and rate dividers

	logic [3:0] pin_rise;

	pin_sync #(.N(4)) u_sync (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.pins_in({tx_clk_pin, rx_clk_pin, ct_clk_pin, ref_clock_in}),
		.level(),
		.rise(pin_rise)
	);
	rate_if #(.W(DIV_W)) rx_rate ();
	rate_if #(.W(DIV_W)) tx_rate ();
	rate_if #(.W(DIV_W)) smp_rate ();

	// Exact rates rely on the nominal reference frequency [RQ4]
	assign rx_rate.tick = pin_rise[0];
	assign tx_rate.tick = pin_rise[0];
	assign smp_rate.tick = pin_rise[0];
	assign rx_rate.divisor = rate_div(rx_clk_sel, aux_control_reg[`AUX_SET_POS],
		extended_mode_reg[`EXT_RATE_POS]); // [RQ1] [RQ3]
	assign tx_rate.divisor = rate_div(tx_clk_sel, aux_control_reg[`AUX_SET_POS],
		extended_mode_reg[`EXT_RATE_POS]); // [RQ1] [RQ3]
	assign smp_rate.divisor = DIV_W'(`SAMPLE_DIV);

	rate_tick_div #(.W(DIV_W)) u_rx_div (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.bus(rx_rate)
	);

	rate_tick_div #(.W(DIV_W)) u_tx_div (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.bus(tx_rate)
	);

	rate_tick_div #(.W(DIV_W)) u_smp_div (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.bus(smp_rate)
	);

	////////////////////////////////////////////////////////////////////
	// State

	baud_ct_pkg::bct_state_t st;
	baud_ct_pkg::bct_state_t nx;

	logic [15:0] preset;
	logic timer_mode;
	logic ref16;
	logic pin16;
	logic ct_tick;
	logic cmd_to_on;
	logic cmd_to_off;
	logic start_cmd;
	logic stop_cmd;
	logic ct_edge;
	logic ready_set;
	logic ready_clr;
	logic [7:0] status_n;

	assign preset = {preset_high_reg, preset_low_reg}; // [RQ22]

	////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		nx = st;

		// Divide-by-16 prescalers for the slow counter sources
		ref16 = 1'b0;
		pin16 = 1'b0;
		if (pin_rise[0]) begin
			nx.pre_ref = st.pre_ref + 4'h1;
			ref16 = (st.pre_ref == `PRE_LAST);
		end
		if (pin_rise[1]) begin
			nx.pre_pin = st.pre_pin + 4'h1;
			pin16 = (st.pre_pin == `PRE_LAST);
		end

		unique case (aux_control_reg[`AUX_SRC_HI:`AUX_SRC_LO]) // [RQ7] [RQ14]
			`CT_SRC_PIN: ct_tick = pin_rise[1];
			`CT_SRC_PIN16: ct_tick = pin16;
			`CT_SRC_REF: ct_tick = pin_rise[0];
			`CT_SRC_REF16: ct_tick = ref16;
		endcase

		cmd_to_on = cmd_wr && command_reg[7:4] == `CMD_TO_ON; // [RQ20]
		cmd_to_off = cmd_wr && command_reg[7:4] == `CMD_TO_OFF; // [RQ20]
		// Timeout mode takes the counter away from software start and stop
		start_cmd = ct_start_rd && !st.timeout_on; // [RQ10]
		stop_cmd = ct_stop_rd && !st.timeout_on; // [RQ10]
		timer_mode = aux_control_reg[`AUX_TIMER_POS] && !st.timeout_on; // [RQ7] [RQ6]

		if (cmd_to_on) begin
			nx.timeout_on = 1'b1; // [RQ20]
			nx.phase = baud_ct_pkg::CT_IDLE;
			nx.ct_out = 1'b1;
		end else if (cmd_to_off) begin
			nx.timeout_on = 1'b0; // [RQ20]
			nx.phase = baud_ct_pkg::CT_IDLE;
			nx.ct_out = 1'b1;
		end else if (st.timeout_on && rx_char_loaded) begin
			nx.phase = baud_ct_pkg::CT_HOLD; // [RQ21]
		end else if (start_cmd) begin
			nx.count = preset; // [RQ11]
			nx.phase = baud_ct_pkg::CT_RUN;
			nx.ct_out = 1'b1;
		end else if (stop_cmd && !timer_mode) begin
			// A stopped counter returns its output high; the timer keeps running
			nx.phase = baud_ct_pkg::CT_IDLE;
			nx.ct_out = 1'b1;
		end else if (ct_tick) begin
			unique case (st.phase)
				baud_ct_pkg::CT_IDLE: nx.phase = baud_ct_pkg::CT_IDLE;
				baud_ct_pkg::CT_HOLD: begin
					nx.count = preset; // [RQ21]
					nx.ct_out = 1'b1;
					nx.phase = baud_ct_pkg::CT_RESTART;
				end
				baud_ct_pkg::CT_RESTART: nx.phase = baud_ct_pkg::CT_RUN; // [RQ21]
				baud_ct_pkg::CT_RUN: begin
					if (timer_mode) begin
						// Preset of zero behaves as one to keep the wave alive
						if (st.count <= 16'h0001) begin
							nx.count = preset; // [RQ13]
							nx.ct_out = ~st.ct_out; // [RQ13]
						end else begin
							nx.count = st.count - 16'h0001;
						end
					end else begin
						nx.count = st.count - 16'h0001; // [RQ19]
						if (st.count == 16'h0001) begin
							nx.ct_out = 1'b0; // [RQ19]
						end
					end
				end
			endcase
		end

		// Counter output rise is one 16x tick when used as a baud source
		ct_edge = nx.ct_out && !st.ct_out; // [RQ8]

		ready_set = st.ct_out && !nx.ct_out; // [RQ9]
		ready_clr = stop_cmd || cmd_to_on || (st.timeout_on && rx_char_loaded); // [RQ12] [RQ20]
		// A fall in the cycle of a clear still leaves the bit set
		nx.ready = ready_set || (st.ready && !ready_clr); // [RQ9] [RQ12]

		nx.rx_en = sel_tick(rx_clk_sel, rx_rate.pulse, ct_edge, pin_rise[2]); // [RQ5]
		nx.tx_en = sel_tick(tx_clk_sel, tx_rate.pulse, ct_edge, pin_rise[3]); // [RQ5]
		nx.rx_1x = (rx_clk_sel == `CSR_EXT1);
		nx.tx_1x = (tx_clk_sel == `CSR_EXT1);
		nx.smp_en = smp_rate.pulse;

		status_n = irq_events;
		status_n[`ISR_CT_POS] = nx.ready;
		nx.status = status_n; // [RQ17]
		nx.irq_n = ~|(status_n & irq_mask_reg); // [RQ15] [RQ16]

		for (int i = 0; i < OP_N; i++) begin
			if (op_irq_en[i]) begin
				// Open drain: pull low while the condition is active, else float
				nx.op_o[i] = 1'b0; // [RQ18]
				nx.op_oe[i] = status_n[op_src(i)]; // [RQ18]
			end else if (i == 0 && op_ct_out_en) begin
				nx.op_o[i] = nx.ct_out; // [RQ8]
				nx.op_oe[i] = 1'b1;
			end else begin
				nx.op_o[i] = gp_out_data[i];
				nx.op_oe[i] = 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			st <= '0;
			st.ct_out <= 1'b1;
			st.irq_n <= 1'b1;
		end else begin
			st <= nx;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Outputs

	assign rx_clk_en = st.rx_en;
	assign tx_clk_en = st.tx_en;
	assign rx_clk_1x = st.rx_1x;
	assign tx_clk_1x = st.tx_1x;
	assign sample_clk_en = st.smp_en;
	assign ct_out = st.ct_out;
	assign ct_count = st.count;
	assign timeout_on = st.timeout_on;
	assign irq_status_reg = st.status;
	assign irq_out_n = st.irq_n;
	assign gp_out_pins_hi_o = st.op_o;
	assign gp_out_pins_hi_oe = st.op_oe;

endmodule : baud_counter_timer
`default_nettype wire

/* baud_counter_timer_asserts.sv */
// Concurrent checks on the port behaviour of the baud and counter/timer block
`timescale 1ns/1ps
`default_nettype none
`include "baud_ct_defines.svh"
module baud_counter_timer_asserts #(
	parameter int OP_N = 5
) (
	input wire logic sys_clk, // System clock
	input wire logic sys_rst, // Synchronous reset, high
	input wire logic [7:0] aux_control_reg, // Mode and source
	input wire logic [3:0] tx_clk_sel, // Transmit select code
	input wire logic [7:0] preset_low_reg, // Preset low byte
	input wire logic [7:0] preset_high_reg, // Preset high byte
	input wire logic ct_start_rd, // Start pulse
	input wire logic ct_stop_rd, // Stop pulse
	input wire logic cmd_wr, // Command pulse
	input wire logic [7:0] command_reg, // Command data
	input wire logic rx_char_loaded, // Character pulse
	input wire logic [7:0] irq_events, // Other conditions
	input wire logic [7:0] irq_mask_reg, // Mask
	input wire logic [OP_N-1:0] op_irq_en, // Pin interrupt mode
	input wire logic tx_clk_1x, // Transmit 1x flag
	input wire logic ct_out, // Counter output
	input wire logic [15:0] ct_count, // Counting register
	input wire logic timeout_on, // Timeout mode
	input wire logic [7:0] irq_status_reg, // Status
	input wire logic irq_out_n, // Interrupt, low
	input wire logic [OP_N-1:0] gp_out_pins_hi_o, // Pin level
	input wire logic [OP_N-1:0] gp_out_pins_hi_oe // Pin enable
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);

	////////////////////////////////////////////////////////////////////////////////
	// Commands outrank start and stop, so only a lone strobe is judged
	sequence s_start;
		ct_start_rd && !timeout_on && !cmd_wr && !rx_char_loaded;
	endsequence
	sequence s_stop;
		ct_stop_rd && !ct_start_rd && !timeout_on && !cmd_wr && !rx_char_loaded;
	endsequence
	sequence s_loaded;
		ct_count == $past({preset_high_reg, preset_low_reg});
	endsequence

	a_start_loads: assert property (s_start |=> s_loaded)
		else $error("start did not load the preset");
	a_stop_clears: assert property (s_stop |=> !irq_status_reg[`ISR_CT_POS] || $fell(ct_out))
		else $error("stop left the ready bit set");
	a_ready_on_fall: assert property ($fell(ct_out) |-> irq_status_reg[`ISR_CT_POS])
		else $error("output fell without ready");
	a_counter_zero: assert property ($fell(ct_out) && !aux_control_reg[`AUX_TIMER_POS]
		&& !timeout_on |-> ct_count == 16'h0000)
		else $error("counter output fell away from zero");
	a_irq_level: assert property (irq_out_n == !(|(irq_status_reg & $past(irq_mask_reg))))
		else $error("interrupt level disagrees with masked status");
	a_status_mirror: assert property (!$past(sys_rst) |->
		(irq_status_reg & 8'hF7) == ($past(irq_events) & 8'hF7))
		else $error("status does not show active conditions");
	a_timeout_enter: assert property (cmd_wr && command_reg[7:4] == `CMD_TO_ON |=>
		timeout_on && !irq_status_reg[`ISR_CT_POS])
		else $error("timeout on command not obeyed");
	a_timeout_leave: assert property (cmd_wr && command_reg[7:4] == `CMD_TO_OFF |=> !timeout_on)
		else $error("timeout off command not obeyed");
	a_char_restart: assert property (timeout_on && rx_char_loaded && !cmd_wr |=>
		!irq_status_reg[`ISR_CT_POS] [*2])
		else $error("character did not restart the timeout");
	a_open_drain: assert property ($past(op_irq_en[0]) && op_irq_en[0] && gp_out_pins_hi_oe[0]
		|-> !gp_out_pins_hi_o[0])
		else $error("interrupt pin driven high");
	a_tx_one_x: assert property (!$past(sys_rst) && $past(tx_clk_sel) == `CSR_EXT1 |-> tx_clk_1x)
		else $error("1x select not flagged");
endmodule : baud_counter_timer_asserts

bind baud_counter_timer baud_counter_timer_asserts #(.OP_N(OP_N)) baud_counter_timer_asserts_inst (
	.sys_clk, .sys_rst, .aux_control_reg, .tx_clk_sel, .preset_low_reg, .preset_high_reg,
	.ct_start_rd, .ct_stop_rd, .cmd_wr, .command_reg, .rx_char_loaded, .irq_events,
	.irq_mask_reg, .op_irq_en, .tx_clk_1x, .ct_out, .ct_count, .timeout_on, .irq_status_reg,
	.irq_out_n, .gp_out_pins_hi_o, .gp_out_pins_hi_oe
);
`default_nettype wire

/* baud_counter_timer_bench.sv */
// Self-checking bench for the baud and counter/timer block
`timescale 1ns/1ps
`default_nettype none
module baud_counter_timer_bench;
	logic sys_clk, sys_rst, ref_clock_in, ref_run;
	logic [7:0] ext_mode, aux, pre_lo, pre_hi, events, mask, cmd, status;
	logic [3:0] rx_sel, tx_sel;
	logic [4:0] op_en, pin_o, pin_oe;
	logic start_rd, stop_rd, cmd_wr, rx_char, rx_en, tx_1x, ct_out, t_on, irq_n;
	logic rx_1x, tx_en, smp, ext_clk, ct_pin_en;
	logic [15:0] count;
	int num_errors = 0;
	int check_count = 0;
	int n;

	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	// Reference at a fixed sys_clk/8 keeps every expected gap an exact cycle count
	initial begin
		ref_clock_in = 1'b0;
		forever begin
			repeat (4) @(negedge sys_clk);
			if (ref_run) ref_clock_in = ~ref_clock_in;
		end
	end

	// External clock pins at sys_clk/4, distinct from the reference so a wrong source shows
	initial begin
		ext_clk = 1'b0;
		forever begin
			repeat (2) @(negedge sys_clk);
			if (ref_run) ext_clk = ~ext_clk;
		end
	end

	host_model host_model_inst (.sys_clk(sys_clk), .ct_start_rd(start_rd), .ct_stop_rd(stop_rd),
		.cmd_wr(cmd_wr), .command_reg(cmd), .rx_char_loaded(rx_char));

	baud_counter_timer baud_counter_timer_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.ref_clock_in(ref_clock_in), .ct_clk_pin(ext_clk), .rx_clk_pin(ext_clk),
		.tx_clk_pin(ext_clk),
		.extended_mode_reg(ext_mode), .aux_control_reg(aux), .rx_clk_sel(rx_sel),
		.tx_clk_sel(tx_sel), .preset_low_reg(pre_lo), .preset_high_reg(pre_hi),
		.ct_start_rd(start_rd), .ct_stop_rd(stop_rd), .cmd_wr(cmd_wr), .command_reg(cmd),
		.rx_char_loaded(rx_char), .irq_events(events), .irq_mask_reg(mask), .op_irq_en(op_en),
		.op_ct_out_en(ct_pin_en), .gp_out_data(5'h00), .rx_clk_en(rx_en), .tx_clk_en(tx_en),
		.rx_clk_1x(rx_1x), .tx_clk_1x(tx_1x), .sample_clk_en(smp), .ct_out(ct_out),
		.ct_count(count),
		.timeout_on(t_on), .irq_status_reg(status), .irq_out_n(irq_n),
		.gp_out_pins_hi_o(pin_o), .gp_out_pins_hi_oe(pin_oe));

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic summarize;
		$display("Checks %0d, errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : summarize

	// Counts falling edges until the counter output reaches the level
	task automatic wait_ct(input logic lvl);
		n = 0;
		while (ct_out !== lvl && n < 400) begin
			@(negedge sys_clk);
			n++;
		end
		if (n >= 400) begin
			num_errors++;
			summarize();
		end
	endtask : wait_ct

	// Skips two pulses so a stale divider count cannot spoil the gap; src 0 rx, 1 tx, 2 tap
	task automatic rx_gap(input logic [15:0] exp, input int src = 0);
		repeat (3) begin
			n = 0;
			do begin
				@(negedge sys_clk);
				n++;
			end while ((src == 0 ? rx_en : src == 1 ? tx_en : smp) !== 1'b1 && n < 1000);
			if (n >= 1000) begin
				num_errors++;
				summarize();
			end
		end
		check(16'(n), exp);
	endtask : rx_gap

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		sys_rst = 1'b1;
		ref_run = 1'b0;
		{ext_mode, rx_sel, tx_sel, events, op_en, ct_pin_en} = '0;
		aux = 8'h20;
		mask = 8'h08;
		{pre_hi, pre_lo} = 16'h1234;
		repeat (6) @(negedge sys_clk);
		sys_rst = 1'b0;
		op_en = 5'h01;
		host_model_inst.op(0, 8'h00);
		check(count, 16'h1234);
		{pre_hi, pre_lo} = 16'h0003;
		host_model_inst.op(0, 8'h00);
		check(count, 16'h0003);
		ref_run = 1'b1;
		wait_ct(1'b0);
		check(count, 16'h0000);
		@(negedge sys_clk);
		check(16'({status[3], irq_n, pin_oe[0], pin_o[0]}), 16'h000A);
		mask = 8'h00;
		repeat (2) @(negedge sys_clk);
		check(16'({status[3], irq_n}), 16'h0003);
		repeat (40) @(negedge sys_clk);
		check(16'(ct_out), 16'h0000);
		host_model_inst.op(1, 8'h00);
		check(16'({status[3], ct_out}), 16'h0001);
		aux = 8'h60;
		{op_en, ct_pin_en} = 6'h01;
		{pre_hi, pre_lo} = 16'h0002;
		host_model_inst.op(0, 8'h00);
		wait_ct(1'b0);
		wait_ct(1'b1);
		check(16'(n), 16'd16);
		check(16'({pin_oe[0], pin_o[0]}), 16'h0003);
		wait_ct(1'b0);
		check(16'(n), 16'd16);
		check(16'({pin_oe[0], pin_o[0]}), 16'h0002);
		rx_sel = 4'hD;
		rx_gap(16'd32);
		rx_sel = 4'hC;
		rx_gap(16'd48);
		rx_gap(16'd768, 2);
		ext_mode = 8'h01;
		aux = 8'hE0;
		rx_sel = 4'h2;
		rx_gap(16'd8);
		rx_sel = 4'hE;
		rx_gap(16'd4);
		tx_sel = 4'hF;
		repeat (2) @(negedge sys_clk);
		check(16'({rx_1x, tx_1x}), 16'h0001);
		rx_gap(16'd4, 1);
		rx_sel = 4'hD;
		aux = 8'h40;
		rx_gap(16'd16);
		aux = 8'h50;
		rx_gap(16'd256);
		aux = 8'h70;
		rx_gap(16'd512);
		aux = 8'h40;
		host_model_inst.op(2, 8'hA0);
		check(16'({t_on, status[3]}), 16'h0002);
		host_model_inst.op(3, 8'h00);
		wait_ct(1'b1);
		wait_ct(1'b0);
		check(16'(status[3]), 16'h0001);
		host_model_inst.op(3, 8'h00);
		check(16'(status[3]), 16'h0000);
		host_model_inst.op(2, 8'hC0);
		check(16'(t_on), 16'h0000);
		ref_run = 1'b0;
		repeat (10) @(negedge sys_clk);
		host_model_inst.op(1, 8'h00);
		events = 8'h81;
		mask = 8'h80;
		repeat (2) @(negedge sys_clk);
		check(16'({status, irq_n}), 16'h0102);
		summarize();
	end
endmodule : baud_counter_timer_bench
`default_nettype wire

/* baud_ct_defines.svh */
// Field positions, codes, divisors and terminal counts of the baud and counter/timer block
`ifndef BAUD_CT_DEFINES_SVH
`define BAUD_CT_DEFINES_SVH

// Auxiliary control field positions
`define AUX_SET_POS 7
`define AUX_TIMER_POS 6
`define AUX_SRC_HI 5
`define AUX_SRC_LO 4

// Counter/timer clock sources in the auxiliary control source field
`define CT_SRC_PIN 2'h0
`define CT_SRC_PIN16 2'h1
`define CT_SRC_REF 2'h2
`define CT_SRC_REF16 2'h3

// Extended mode bit that unlocks the three high rates
`define EXT_RATE_POS 0

// Clock select codes beyond the generator rates
`define CSR_CT 4'hD
`define CSR_EXT16 4'hE
`define CSR_EXT1 4'hF

// Command register upper nibbles
`define CMD_TO_ON 4'hA
`define CMD_TO_OFF 4'hC

// Status bit positions
`define ISR_TX_POS 0
`define ISR_RX_POS 1
`define ISR_CT_POS 3

// Sampling tap divisor (38.4 kHz from the nominal reference)
`define SAMPLE_DIV 16'h0060

// Prescaler terminal count for the divide-by-16 sources
`define PRE_LAST 4'hF

`endif

/* baud_ct_pkg.sv */
// Types shared by the baud and counter/timer block
`default_nettype none
package baud_ct_pkg;

	typedef enum logic [1:0] {
		CT_IDLE = 2'b00,
		CT_RUN = 2'b01,
		CT_HOLD = 2'b10,
		CT_RESTART = 2'b11
	} ct_phase_t;

	typedef struct packed {
		ct_phase_t phase;
		logic [15:0] count;
		logic ct_out;
		logic ready;
		logic timeout_on;
		logic [3:0] pre_ref;
		logic [3:0] pre_pin;
		logic rx_en;
		logic tx_en;
		logic rx_1x;
		logic tx_1x;
		logic smp_en;
		logic [7:0] status;
		logic irq_n;
		logic [4:0] op_o;
		logic [4:0] op_oe;
	} bct_state_t;

endpackage : baud_ct_pkg
`default_nettype wire

/* host_model.sv */
// Host processor model issuing start, stop, command and character strobes
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input wire logic sys_clk, // System clock
	output logic ct_start_rd, // Start read strobe
	output logic ct_stop_rd, // Stop read strobe
	output logic cmd_wr, // Command write strobe
	output logic [7:0] command_reg, // Command data
	output logic rx_char_loaded // Character loaded strobe
);
	initial begin
		{ct_start_rd, ct_stop_rd, cmd_wr, rx_char_loaded} = 4'h0;
		command_reg = 8'h00;
	end

	// One-cycle strobe raised and dropped on falling edges, clear of the sampling edge
	task automatic op(input int kind, input logic [7:0] data);
		@(negedge sys_clk);
		command_reg = data;
		case (kind)
			0: ct_start_rd = 1'b1;
			1: ct_stop_rd = 1'b1;
			2: cmd_wr = 1'b1;
			default: rx_char_loaded = 1'b1;
		endcase
		@(negedge sys_clk);
		{ct_start_rd, ct_stop_rd, cmd_wr, rx_char_loaded} = 4'h0;
	endtask : op
endmodule : host_model
`default_nettype wire

/* pin_sync.sv */
// Three-stage pin synchroniser with agreement filter and rising-edge pulse
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter int N = 4
) (
	input wire logic sys_clk, // System clock
	input wire logic sys_rst, // Synchronous reset, high
	input wire logic [N-1:0] pins_in, // Asynchronous pins
	output logic [N-1:0] level, // Filtered level
	output logic [N-1:0] rise // One-cycle pulse on a filtered rise
);
	typedef struct packed {
		logic [N-1:0] s1;
		logic [N-1:0] s2;
		logic [N-1:0] s3;
		logic [N-1:0] lvl;
		logic [N-1:0] rise;
	} sync_state_t;

	sync_state_t st;
	sync_state_t nx;

	// A change counts only once the second and third stages agree
	always_comb begin
		nx = st;
		nx.s1 = pins_in;
		nx.s2 = st.s1;
		nx.s3 = st.s2;
		nx.lvl = (st.s2 & st.s3) | (st.lvl & (st.s2 ^ st.s3));
		nx.rise = nx.lvl & ~st.lvl;
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			st <= '0;
		end else begin
			st <= nx;
		end
	end

	assign level = st.lvl;
	assign rise = st.rise;
endmodule : pin_sync
`default_nettype wire

/* rate_if.sv */
// Divisor request and tick answer between the block and a rate divider
`timescale 1ns/1ps
`default_nettype none
interface rate_if #(
	parameter int W = 16
);
	logic tick;
	logic [W-1:0] divisor;
	logic pulse;

	modport src (output tick, output divisor, input pulse);
	modport div (input tick, input divisor, output pulse);
endinterface : rate_if
`default_nettype wire

/* rate_tick_div.sv */
// Divides an input tick stream by a programmable divisor into single pulses
`timescale 1ns/1ps
`default_nettype none
module rate_tick_div #(
	parameter int W = 16
) (
	input wire logic sys_clk, // System clock
	input wire logic sys_rst, // Synchronous reset, high
	rate_if.div bus // Tick in, divisor in, pulse out
);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic pulse;
	} div_state_t;

	div_state_t st;
	div_state_t nx;

	// The >= compare absorbs a divisor lowered below the running count
	always_comb begin
		nx = st;
		nx.pulse = 1'b0;
		if (bus.tick) begin
			if (bus.divisor == '0 || st.cnt >= bus.divisor - W'(1)) begin
				nx.cnt = '0;
				nx.pulse = 1'b1;
			end else begin
				nx.cnt = st.cnt + W'(1);
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			st <= '0;
		end else begin
			st <= nx;
		end
	end

	assign bus.pulse = st.pulse;
endmodule : rate_tick_div
`default_nettype wire
